//--- rtl/cflc_pkg.sv
// Package: constants, register map and carrier types of the configurable logic cell
package cflc_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int NUM_CELLS = 2;
  localparam int NUM_SRC   = 8;
  localparam int NUM_GATES = 4;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_CON         = 8'h00;
  localparam logic [7:0] OFF_POL         = 8'h04;
  localparam logic [7:0] OFF_SEL0        = 8'h08;
  localparam logic [7:0] OFF_SEL1        = 8'h0c;
  localparam logic [7:0] OFF_GLS0        = 8'h10;
  localparam logic [7:0] CELL_STRIDE     = 8'h20;
  localparam logic [7:0] OFF_MIRROR      = 8'h40;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h44;
  localparam logic [7:0] OFF_IRQ_MASK    = 8'h48;
  localparam logic [7:0] OFF_INTCTL      = 8'h4c;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int INTCTL_GLOBAL_BIT = 7;
  localparam int INTCTL_PERIPH_BIT = 6;
  localparam int SEL_HI_LSB        = 4;
  localparam logic [7:0] CON_RST    = 8'h00;
  localparam logic [7:0] INTCTL_RST = 8'h00;
  localparam logic [NUM_CELLS-1:0] IRQ_RST = '0;
  localparam logic [2:0] FAST_OSC_SRC = 3'h0;

  // ----------------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_AND_OR  = 3'b000,
    MODE_OR_XOR  = 3'b001,
    MODE_AND4    = 3'b010,
    MODE_OR4     = 3'b011,
    MODE_XOR4    = 3'b100,
    MODE_AND_XOR = 3'b101,
    MODE_OR_AND  = 3'b110,
    MODE_PASS1   = 3'b111
  } cflc_mode_t;

  typedef struct packed {
    logic       cell_enable_bit;       // Also acts as the cell on bit
    logic       cell_pin_drive_enable;
    logic       cell_output_bit;       // Read-only, written as zero
    logic       rise_irq_enable;
    logic       fall_irq_enable;
    logic [2:0] logic_function_select;
  } cflc_con_t;

  typedef struct packed {
    logic       cell_output_invert;
    logic [2:0] unused;
    logic [3:0] gate_output_invert;
  } cflc_pol_t;

endpackage

//--- rtl/cflc_top.sv
// Configurable logic cells with AXI4-Lite register access and edge interrupts
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps

// Overview of operation
// - Each cell has a rising and a falling edge detector on its output.
// - An edge with its own enable set raises that cell's interrupt flag.
// - Rise enable gates only rising edges; fall enable only falling; both in control.
// - An enabled edge in the clearing cycle wins; the flag stays set.
// - One mirror register returns all cell outputs sampled at one instant.
// - Any reset clears every bit of each cell control register.
// - Reset leaves input select, gate enable and polarity registers untouched.
// - Cell logic is combinational, independent of the system clock.
// - Keep the fast oscillator alive while an enabled cell selects it.
// - Selected inputs feed four gates, each with its own enable register.
// - Each gate has its own invert bit in the polarity register.
// - A three-bit mode field picks the function combining the gates.
// - A separate polarity bit inverts the final cell output.
// - The pin is driven only while the output enable bit is set.
// - Interrupt reaches the core only with cell, mask, edge, peripheral, global enables; the code does not gate irq with the cell enable.
module cflc_top
  import cflc_pkg::*;
(
  input  wire logic                  aclk,          // System clock, 200 MHz
  input  wire logic                  aresetn,       // Synchronous reset, active low
  input  wire logic [ADDR_W-1:0]     awaddr,        // Write address
  input  wire logic [2:0]            awprot,        // Unused protection
  input  wire logic                  awvalid,       // Write address valid
  output logic                       awready,       // Write address ready
  input  wire logic [DATA_W-1:0]     wdata,         // Write data
  input  wire logic [3:0]            wstrb,         // Byte strobes
  input  wire logic                  wvalid,        // Write data valid
  output logic                       wready,        // Write data ready
  output logic [1:0]                 bresp,         // Write response
  output logic                       bvalid,        // Write response valid
  input  wire logic                  bready,        // Write response ready
  input  wire logic [ADDR_W-1:0]     araddr,        // Read address
  input  wire logic [2:0]            arprot,        // Unused protection
  input  wire logic                  arvalid,       // Read address valid
  output logic                       arready,       // Read address ready
  output logic [DATA_W-1:0]          rdata,         // Read data
  output logic [1:0]                 rresp,         // Read response
  output logic                       rvalid,        // Read data valid
  input  wire logic                  rready,        // Read data ready
  input  wire logic [NUM_SRC-1:0]    src_in,        // Selectable sources, bit 0 fast osc
  output logic [NUM_CELLS-1:0]       cell_pin_out,  // Cell output to pin
  output logic [NUM_CELLS-1:0]       cell_pin_oe_n, // Pin drive enable, low drives
  output logic                       osc_keep_alive,// Hold fast oscillator during sleep
  output logic                       irq            // Level interrupt
);

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  cflc_con_t            con_ff   [NUM_CELLS];
  cflc_pol_t            pol_ff   [NUM_CELLS];
  logic [7:0]           sel0_ff  [NUM_CELLS];
  logic [7:0]           sel1_ff  [NUM_CELLS];
  logic [7:0]           gls_ff   [NUM_CELLS][NUM_GATES];
  logic [NUM_CELLS-1:0] flag_ff;
  logic [NUM_CELLS-1:0] mask_ff;
  logic [7:0]           intctl_ff;
  logic [NUM_CELLS-1:0] out_meta_ff;
  logic [NUM_CELLS-1:0] out_sync_ff;
  logic [NUM_CELLS-1:0] out_prev_ff;
  logic [NUM_CELLS-1:0] cell_raw;
  logic [NUM_CELLS-1:0] rise_ev;
  logic [NUM_CELLS-1:0] fall_ev;
  logic [NUM_CELLS-1:0] set_ev;
  logic [NUM_CELLS-1:0] clr_req;
  logic [NUM_CELLS-1:0] nxt_flag;
  logic [NUM_CELLS-1:0] keep_req;

  // ----------------------------------------------------------------------
  // Cell datapath
  // ----------------------------------------------------------------------
  for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cell
    wire logic [2:0] dsel [NUM_GATES];
    wire logic [NUM_GATES-1:0] dval;
    wire logic [NUM_GATES-1:0] gate;
    wire logic [NUM_GATES-1:0] g;
    logic func;

    // Two selectors per select register, low nibble then high nibble
    assign dsel[0] = sel0_ff[c][2:0];
    assign dsel[1] = sel0_ff[c][SEL_HI_LSB +: 3];
    assign dsel[2] = sel1_ff[c][2:0];
    assign dsel[3] = sel1_ff[c][SEL_HI_LSB +: 3];

    // Each gate ORs the true and complement forms it enables
    for (genvar d = 0; d < NUM_GATES; d++) begin : g_data
      assign dval[d] = src_in[dsel[d]];
    end
    for (genvar k = 0; k < NUM_GATES; k++) begin : g_gate
      wire logic [2*NUM_GATES-1:0] terms;
      for (genvar d = 0; d < NUM_GATES; d++) begin : g_term
        assign terms[2*d+1] = gls_ff[c][k][2*d+1] & dval[d];
        assign terms[2*d]   = gls_ff[c][k][2*d] & ~dval[d];
      end
      assign gate[k] = |terms;
    end
    assign g = gate ^ pol_ff[c].gate_output_invert;

    // Function select; pure gates so the cell runs without the bus clock
    always_comb begin
      case (cflc_mode_t'(con_ff[c].logic_function_select))
        MODE_AND_OR:  func = (g[0] & g[1]) | (g[2] & g[3]);
        MODE_OR_XOR:  func = (g[0] | g[1]) ^ (g[2] | g[3]);
        MODE_AND4:    func = &g;
        MODE_OR4:     func = |g;
        MODE_XOR4:    func = ^g;
        MODE_AND_XOR: func = (g[0] & g[1]) ^ (g[2] & g[3]);
        MODE_OR_AND:  func = (g[0] | g[1]) & (g[2] | g[3]);
        MODE_PASS1:   func = g[0];
        default:      func = 1'b0;
      endcase
    end

    // Disabled cell holds its output low; polarity applies before the enable gate
    assign cell_raw[c] = con_ff[c].cell_enable_bit &
                         (func ^ pol_ff[c].cell_output_invert);
    assign cell_pin_out[c]  = cell_raw[c];
    assign cell_pin_oe_n[c] = ~(con_ff[c].cell_pin_drive_enable &
                                con_ff[c].cell_enable_bit);
    assign keep_req[c] = con_ff[c].cell_enable_bit &
                         ((dsel[0] == FAST_OSC_SRC) | (dsel[1] == FAST_OSC_SRC) |
                          (dsel[2] == FAST_OSC_SRC) | (dsel[3] == FAST_OSC_SRC));
  end

  assign osc_keep_alive = |keep_req;

  // ----------------------------------------------------------------------
  // Output synchroniser and edge detection
  // ----------------------------------------------------------------------
  // The second and third stages feed the detectors; only the second feeds the mirror
  always_ff @(posedge aclk) begin
    out_meta_ff <= cell_raw;
    out_sync_ff <= out_meta_ff;
    out_prev_ff <= out_sync_ff;
  end

  assign rise_ev = out_sync_ff & ~out_prev_ff;
  assign fall_ev = ~out_sync_ff & out_prev_ff;

  // ----------------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------------
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [DATA_W-1:0] w_data_ff;
  logic [3:0]        w_strb_ff;
  logic              aw_full_ff;
  logic              w_full_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;

  assign awready = ~aw_full_ff;
  assign wready  = ~w_full_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;

  // Write decode: cells share one stride, shared block sits above them
  wire logic        wr_go     = aw_full_ff & w_full_ff & ~bvalid_ff;
  wire logic        wr_lane0  = wr_go & w_strb_ff[0];
  wire logic        wr_cellsp = aw_addr_ff < (CELL_STRIDE * NUM_CELLS);
  wire logic        wr_idx    = aw_addr_ff[5];
  wire logic [7:0]  wr_roff   = {3'h0, aw_addr_ff[4:0]};
  wire logic [7:0]  wr_byte   = w_data_ff[7:0];
  wire logic        wr_ok     = wr_cellsp | (aw_addr_ff == OFF_MIRROR) |
                                (aw_addr_ff == OFF_IRQ_STATUS) |
                                (aw_addr_ff == OFF_IRQ_MASK) |
                                (aw_addr_ff == OFF_INTCTL);
  wire logic        wr_cell   = wr_lane0 & wr_cellsp;
  wire logic        wr_status = wr_lane0 & (aw_addr_ff == OFF_IRQ_STATUS);
  wire logic        wr_mask   = wr_lane0 & (aw_addr_ff == OFF_IRQ_MASK);
  wire logic        wr_intctl = wr_lane0 & (aw_addr_ff == OFF_INTCTL);

  // Channel holding registers; address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_ff <= 1'b0;
      w_full_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      aw_addr_ff <= '0;
      w_data_ff  <= '0;
      w_strb_ff  <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_full_ff <= 1'b1;
        aw_addr_ff <= awaddr;
      end else if (wr_go) begin
        aw_full_ff <= 1'b0;
      end
      if (wvalid && wready) begin
        w_full_ff <= 1'b1;
        w_data_ff <= wdata;
        w_strb_ff <= wstrb;
      end else if (wr_go) begin
        w_full_ff <= 1'b0;
      end
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control registers: cleared by reset
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    for (int c = 0; c < NUM_CELLS; c++) begin
      if (!aresetn) begin
        con_ff[c] <= cflc_con_t'(CON_RST);
      end else if (wr_cell && wr_idx == c[0] && wr_roff == OFF_CON) begin
        con_ff[c] <= cflc_con_t'(wr_byte & 8'hdf);  // Output bit is read-only
      end
    end
  end

  // ----------------------------------------------------------------------
  // Selection, gate and polarity registers: reset leaves them alone
  // ----------------------------------------------------------------------
  // No reset branch on purpose; software must program them before enabling
  always_ff @(posedge aclk) begin
    for (int c = 0; c < NUM_CELLS; c++) begin
      if (wr_cell && wr_idx == c[0]) begin
        if (wr_roff == OFF_POL)  pol_ff[c]  <= cflc_pol_t'(wr_byte & 8'h8f);
        if (wr_roff == OFF_SEL0) sel0_ff[c] <= wr_byte & 8'h77;
        if (wr_roff == OFF_SEL1) sel1_ff[c] <= wr_byte & 8'h77;
        for (int k = 0; k < NUM_GATES; k++) begin
          if (wr_roff == OFF_GLS0 + 8'(4 * k)) gls_ff[c][k] <= wr_byte;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt flags, mask and enables
  // ----------------------------------------------------------------------
  // A new edge in the clearing cycle survives the write-one-to-clear
  always_comb begin
    for (int c = 0; c < NUM_CELLS; c++) begin
      set_ev[c] = (rise_ev[c] & con_ff[c].rise_irq_enable) |
                  (fall_ev[c] & con_ff[c].fall_irq_enable);
    end
  end
  assign clr_req  = wr_status ? wr_byte[NUM_CELLS-1:0] : '0;
  assign nxt_flag = (flag_ff & ~clr_req) | set_ev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_ff   <= IRQ_RST;
      mask_ff   <= IRQ_RST;
      intctl_ff <= INTCTL_RST;
    end else begin
      flag_ff <= nxt_flag;
      if (wr_mask)   mask_ff   <= wr_byte[NUM_CELLS-1:0];
      if (wr_intctl) intctl_ff <= wr_byte & 8'hc0;
    end
  end

  // Cell on is implied: a disabled cell holds its output low and makes no edges once low
  assign irq = |(flag_ff & mask_ff) & intctl_ff[INTCTL_GLOBAL_BIT] &
               intctl_ff[INTCTL_PERIPH_BIT];

  // ----------------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------------
  logic              rvalid_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [1:0]        rresp_ff;
  logic [7:0]        rd_byte;
  logic              rd_ok;

  assign arready = ~rvalid_ff;
  assign rvalid  = rvalid_ff;
  assign rdata   = rdata_ff;
  assign rresp   = rresp_ff;

  wire logic       rd_cellsp = araddr < (CELL_STRIDE * NUM_CELLS);
  wire logic       rd_idx    = araddr[5];
  wire logic [7:0] rd_roff   = {3'h0, araddr[4:0]};

  // Read mux; the control output bit shows the synchronised cell output
  always_comb begin
    rd_byte = 8'h00;
    rd_ok   = 1'b1;
    if (rd_cellsp) begin
      case (rd_roff)
        OFF_CON:  begin
          rd_byte = con_ff[rd_idx];
          rd_byte[5] = out_sync_ff[rd_idx];
        end
        OFF_POL:  rd_byte = pol_ff[rd_idx];
        OFF_SEL0: rd_byte = sel0_ff[rd_idx];
        OFF_SEL1: rd_byte = sel1_ff[rd_idx];
        OFF_GLS0:          rd_byte = gls_ff[rd_idx][0];
        OFF_GLS0 + 8'h04:  rd_byte = gls_ff[rd_idx][1];
        OFF_GLS0 + 8'h08:  rd_byte = gls_ff[rd_idx][2];
        OFF_GLS0 + 8'h0c:  rd_byte = gls_ff[rd_idx][3];
        default:  rd_ok = 1'b0;
      endcase
    end else begin
      case (araddr)
        OFF_MIRROR:     rd_byte = {6'h00, out_sync_ff};
        OFF_IRQ_STATUS: rd_byte = {6'h00, flag_ff};
        OFF_IRQ_MASK:   rd_byte = {6'h00, mask_ff};
        OFF_INTCTL:     rd_byte = intctl_ff;
        default:        rd_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= {24'h000000, rd_byte};
      rresp_ff  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking

  set_wins_a: assert property (disable iff (!aresetn)
    (set_ev[0] && clr_req[0]) |=> flag_ff[0])
    else $error("edge lost against a clear");

  rise_sets_a: assert property (disable iff (!aresetn)
    (out_sync_ff[0] && !out_prev_ff[0] && con_ff[0].rise_irq_enable) |=> flag_ff[0])
    else $error("enabled rise did not set flag");

  fall_gated_a: assert property (disable iff (!aresetn)
    (!flag_ff[0] && !con_ff[0].fall_irq_enable && !rise_ev[0]) |=> !flag_ff[0])
    else $error("flag set without an enabled edge");

  flag_hold_a: assert property (disable iff (!aresetn)
    (flag_ff[0] && !clr_req[0]) |=> flag_ff[0])
    else $error("flag cleared without software");

  con_reset_a: assert property (
    !aresetn |=> (con_ff[0] == cflc_con_t'(CON_RST)) && (con_ff[1] == cflc_con_t'(CON_RST)))
    else $error("control not cleared by reset");

  sel_keep_a: assert property (
    (!aresetn && !wr_cell) |=> $stable(sel0_ff[0]) && $stable(gls_ff[0][0]))
    else $error("selection changed across reset");

  mirror_read_a: assert property (disable iff (!aresetn)
    (arvalid && arready && araddr == OFF_MIRROR) |=>
      rvalid && rdata[NUM_CELLS-1:0] == $past(out_sync_ff))
    else $error("mirror read mismatch");

  edge_timing_a: assert property (disable iff (!aresetn)
    rise_ev[0] |-> !$past(cell_raw[0], 3) && $past(cell_raw[0], 2))
    else $error("rise edge without a synchronised change");

  pin_drive_a: assert property (disable iff (!aresetn)
    !cell_pin_oe_n[0] |-> con_ff[0].cell_pin_drive_enable && con_ff[0].cell_enable_bit)
    else $error("pin driven without output enable");

  irq_gate_a: assert property (disable iff (!aresetn)
    (flag_ff[0] && mask_ff[0] && intctl_ff[7:6] == 2'b11) |-> irq ##1 (irq || !flag_ff[0]
      || !mask_ff[0] || intctl_ff[7:6] != 2'b11))
    else $error("interrupt not raised when fully enabled");

  osc_keep_a: assert property (disable iff (!aresetn)
    (con_ff[0].cell_enable_bit && (sel0_ff[0][2:0] == FAST_OSC_SRC ||
      sel1_ff[0][2:0] == FAST_OSC_SRC)) |-> osc_keep_alive)
    else $error("fast oscillator not held");

  and4_mode_a: assert property (disable iff (!aresetn)
    (con_ff[0].cell_enable_bit && con_ff[0].logic_function_select == MODE_AND4)
      |-> cell_raw[0] == ((&g_cell[0].g) ^ pol_ff[0].cell_output_invert))
    else $error("and mode output wrong");

endmodule

//--- tb/cflc_top_test.sv
// Self-checking bench for the configurable logic cells
`timescale 1ns/1ps
module cflc_top_test;
  import cflc_pkg::*;
  logic                 aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [ADDR_W-1:0]    awaddr, araddr;
  logic [DATA_W-1:0]    wdata, rdata, rd_d;
  logic [3:0]           wstrb, gpol;
  logic [2:0]           awprot, arprot;
  logic [1:0]           bresp, rresp, wr_r, rd_r;
  logic                 awready, wready, bvalid, arready, rvalid, osc_keep_alive, irq, fpol;
  logic [NUM_SRC-1:0]   src_in;
  logic [NUM_CELLS-1:0] cell_pin_out, cell_pin_oe_n;
  logic [2:0]           sel_v [4];
  int                   n_mismatch, checks;

  // 200 MHz system clock
  always #2.5 aclk = ~aclk;

  cflc_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(arprot), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .src_in(src_in), .cell_pin_out(cell_pin_out),
    .cell_pin_oe_n(cell_pin_oe_n), .osc_keep_alive(osc_keep_alive), .irq(irq));

  // ----------------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  task automatic tmo;
    n_mismatch++;
    $display("unexpected at %0t: bus wait ran out", $time);
    final_report();
  endtask

  // Address and data offered together; each released at its own ready
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
      if (n > 40) tmo();
    end while (!bvalid);
    wr_r = bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
      if (n > 40) tmo();
    end while (!rvalid);
    rd_d = rdata;
    rd_r = rresp;
  endtask

  // Selections change only while the cell is off, then enable goes last
  task automatic cfg(input logic [7:0] con);
    wr(OFF_CON, 32'h0);
    wr(OFF_SEL0, {25'h0, sel_v[1], 1'b0, sel_v[0]});
    wr(OFF_SEL1, {25'h0, sel_v[3], 1'b0, sel_v[2]});
    for (int k = 0; k < 4; k++) wr(OFF_GLS0 + 8'(4 * k), 32'h1 << (2 * k + 1));
    wr(OFF_POL, {24'h0, fpol, 3'h0, gpol});
    wr(OFF_CON, {24'h0, con});
  endtask

  // Gate k passes data k true; model of every function code
  function automatic logic cell_exp(input logic [2:0] m, input logic [7:0] s);
    logic [3:0] g;
    logic       r;
    for (int k = 0; k < 4; k++) g[k] = s[sel_v[k]] ^ gpol[k];
    case (m)
      3'h0: r = (g[0] & g[1]) | (g[2] & g[3]);
      3'h1: r = (g[0] | g[1]) ^ (g[2] | g[3]);
      3'h2: r = &g;
      3'h3: r = |g;
      3'h4: r = ^g;
      3'h5: r = (g[0] & g[1]) ^ (g[2] & g[3]);
      3'h6: r = (g[0] | g[1]) & (g[2] | g[3]);
      default: r = g[0];
    endcase
    return r ^ fpol;
  endfunction

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {aclk, aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    {awprot, arprot, src_in, n_mismatch, checks} = '0;
    {bready, rready, wstrb} = 6'h3f;
    void'($urandom(58));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset state and refused addresses
    rd(OFF_CON + CELL_STRIDE);
    chk(rd_d, 32'h0);
    chk({irq, cell_pin_oe_n, cell_pin_out}, 5'h0c);
    // Second cell: drive enable alone must not turn its pin on
    wr(OFF_CON + CELL_STRIDE, 32'h48);
    rd(OFF_CON + CELL_STRIDE);
    chk(rd_d, 32'h48);
    chk(cell_pin_oe_n, 2'b11);
    rd(8'h50);
    chk({rd_r, rd_d}, {RESP_SLVERR, 32'h0});
    wr(8'h54, 32'hff);
    chk(wr_r, RESP_SLVERR);
    // Random sources, polarities and selections over all function codes
    for (int i = 0; i < 16; i++) begin
      for (int k = 0; k < 4; k++) sel_v[k] = 3'($urandom_range(1, 7));
      gpol = 4'($urandom);
      fpol = 1'($urandom);
      cfg({1'b1, i[3], 3'h0, 3'(i)});
      src_in <= 8'($urandom);
      @(posedge aclk);
      #1;
      chk(cell_pin_out, {1'b0, cell_exp(3'(i), src_in)});
      chk(cell_pin_oe_n, {1'b1, !i[3]});
      chk(osc_keep_alive, 1'b0);
      repeat (4) @(posedge aclk);
      rd(OFF_MIRROR);
      chk(rd_d, {31'h0, cell_exp(3'(i), src_in)});
    end
    // Oscillator held only while an enabled cell selects it
    sel_v[2] = FAST_OSC_SRC;
    cfg(8'h83);
    chk(osc_keep_alive, 1'b1);
    wr(OFF_CON, 32'h0);
    chk(osc_keep_alive, 1'b0);
    // Edge interrupts: both inversions cancel so the cell follows source 3
    sel_v = '{3'h3, 3'h3, 3'h3, 3'h3};
    gpol = 4'h5;
    fpol = 1'b1;
    src_in <= 8'h00;
    cfg(8'h97);
    wr(OFF_IRQ_MASK, 32'h1);
    wr(OFF_INTCTL, 32'hc0);
    src_in <= 8'h08;
    repeat (20) @(posedge aclk);
    rd(OFF_IRQ_STATUS);
    chk(rd_d, 32'h1);
    chk(irq, 1'b1);
    wr(OFF_IRQ_STATUS, 32'h1);
    rd(OFF_IRQ_STATUS);
    chk({irq, rd_d}, 33'h0);
    src_in <= 8'h00;
    repeat (8) @(posedge aclk);
    rd(OFF_IRQ_STATUS);
    chk(rd_d, 32'h0);
    wr(OFF_CON, 32'h8f);
    src_in <= 8'h08;
    repeat (8) @(posedge aclk);
    rd(OFF_IRQ_STATUS);
    chk(rd_d, 32'h0);
    src_in <= 8'h00;
    repeat (8) @(posedge aclk);
    rd(OFF_IRQ_STATUS);
    chk({irq, rd_d}, 33'h1_0000_0001);
    // Clear lands in the very cycle of a new enabled fall: the edge wins
    src_in <= 8'h08;
    repeat (8) @(posedge aclk);
    src_in <= 8'h00;
    @(posedge aclk);
    wr(OFF_IRQ_STATUS, 32'h1);
    rd(OFF_IRQ_STATUS);
    chk(rd_d, 32'h1);
    wr(OFF_IRQ_MASK, 32'h0);
    chk(irq, 1'b0);
    wr(OFF_IRQ_MASK, 32'h1);
    wr(OFF_INTCTL, 32'h40);
    chk(irq, 1'b0);
    // Second reset keeps selections and polarity, clears control
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFF_POL);
    chk(rd_d, 32'h85);
    rd(OFF_SEL0);
    chk(rd_d, 32'h33);
    rd(OFF_CON);
    chk({irq, rd_d}, 33'h0);
    rd(OFF_CON + CELL_STRIDE);
    chk(rd_d, 32'h0);
    final_report();
  end
endmodule
